// *** hdl/cpu_identification_regs.sv ***
`timescale 1ns/1ns
// What this block does
// - every register is 32 bits, read-only, privileged access only
// - c0,c0 with second opcode 1 returns cache geometry
// - cache geometry bits 31-29 zero, bits 28-25 hold class code 1110
// - cache geometry bit 24 is one: separate instruction and data caches
// - data field: size code, four-way, eight-word lines, other bits zero
// - instruction field bit 11 is zero for 16KB, one for larger
// - instruction field: size code, four-way, eight-word lines, other bits zero
// - c0,c0 with second opcode 3 returns translation buffer description
// - translation buffer bits 23-16 report zero lockable instruction entries
// - translation buffer bits 15-8 report eight lockable data entries
// - translation buffer bit 0 is zero: one unified buffer
// - c0,c0 with second opcode 5 returns processor number
// - cluster field follows the cluster number pins
// - processor number unique per cpu, 0 up to 3
// - c0,c1 selects features by second opcode: processor, debug, memory model
// - feature slot with second opcode 3 reads all zeros
// - execution state features read 0x111 with upper bits zero
// - programmer model features read 0x1 with upper bits zero
module cpu_identification_regs #(
  parameter int unsigned NUM_CPUS = 4,
  parameter logic [31:0] DEBUG_FEATURES = 32'h0000_0000,
  parameter logic [31:0] MM_FEATURES0 = 32'h0000_0000,
  parameter logic [31:0] MM_FEATURES1 = 32'h0000_0000,
  parameter logic [31:0] MM_FEATURES2 = 32'h0000_0000,
  parameter logic [31:0] MM_FEATURES3 = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic xfer_priv,
  input wire logic [2:0] xfer_op1,
  input wire logic [3:0] xfer_crn,
  input wire logic [3:0] xfer_crm,
  input wire logic [2:0] xfer_op2,
  input wire logic [3:0] cluster_number_pins,
  input wire logic [1:0] cpu_slot_pins,
  input wire logic [1:0] dcache_size_pins,
  input wire logic [1:0] icache_size_pins,
  output logic [31:0] rd_data_q,
  output logic rd_valid_q,
  output logic undef_q,
  output logic miss_q,
  output logic ready_q
);

  // --------------------------------------------------------------
  // local constants
  // --------------------------------------------------------------
  // highest slot number this configuration may report;
  // a single-cpu build reports slot 0 and nothing else
  localparam logic [1:0] MAX_SLOT = 2'(NUM_CPUS - 1);
  localparam int PIN_W = 10;

  typedef enum logic [1:0] {
    st_settle,
    st_snap,
    st_ready
  } cfg_state_e;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [3:0] sync_cluster;
  logic [1:0] sync_slot;
  logic [1:0] sync_data_cache_field;
  logic [1:0] sync_instruction_cache_field;
  cfg_state_e cfg_state_q;
  cfg_state_e cfg_state_d;
  logic [1:0] settle_cnt_q;
  logic [3:0] cluster_q;
  logic [1:0] slot_q;
  logic [1:0] data_cache_field_q;
  logic [1:0] instruction_cache_field_q;
  logic [1:0] slot_clamped;
  logic [31:0] cache_geometry;
  logic [31:0] translation_buffer_geometry;
  logic [31:0] processor_number;
  logic [31:0] execution_state_features;
  logic [31:0] programmer_model_features;
  logic sel_hit;
  logic [31:0] sel_val;
  logic take;
  logic refuse;

  cache_field_if data_cache_field ();
  cache_field_if instruction_cache_field ();

  // --------------------------------------------------------------
  // configuration pin synchronisers
  // --------------------------------------------------------------
  // pins are static but arrive from outside the clock domain;
  // only the second stage is ever looked at
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce) begin
      pin_meta_q <= {cluster_number_pins, cpu_slot_pins, dcache_size_pins, icache_size_pins};
      pin_sync_q <= pin_meta_q;
    end
  end

  // split the synchronised vector back into its groups; the
  // concatenation mirrors the capture above, so no bit positions
  // have to be kept in step by hand
  assign {sync_cluster, sync_slot, sync_data_cache_field, sync_instruction_cache_field} = pin_sync_q;

  // --------------------------------------------------------------
  // configuration capture sequence
  // --------------------------------------------------------------
  // wait until the synchroniser has flushed its reset zeros,
  // then take one snapshot; requests before that get no answer
  always_comb begin
    cfg_state_d = cfg_state_q;
    case (cfg_state_q)
      st_settle: begin
        if (settle_cnt_q == cpu_id_pkg::SETTLE_CYCLES) begin
          cfg_state_d = st_snap;
        end
      end
      st_snap: begin
        cfg_state_d = st_ready;
      end
      st_ready: begin
        cfg_state_d = st_ready;
      end
      default: begin
        cfg_state_d = st_settle;
      end
    endcase
  end

  // state register of the capture sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_state_q <= st_settle;
    end else if (ce) begin
      cfg_state_q <= cfg_state_d;
    end
  end

  // settle counter stops at its limit; two edges would flush the
  // synchroniser, the extra one is margin for a slow strap edge
  // and costs a single cycle once per reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt_q <= '0;
    end else if (ce) begin
      if (cfg_state_q == st_settle && settle_cnt_q != cpu_id_pkg::SETTLE_CYCLES) begin
        settle_cnt_q <= settle_cnt_q + 2'h1;
      end
    end
  end

  // snapshot of the static configuration; later pin wiggles are
  // deliberately ignored so a read never sees a half-changed value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cluster_q <= '0;
      slot_q <= '0;
      data_cache_field_q <= '0;
      instruction_cache_field_q <= '0;
    end else if (ce) begin
      if (cfg_state_q == st_snap) begin
        cluster_q <= sync_cluster;
        slot_q <= sync_slot;
        data_cache_field_q <= sync_data_cache_field;
        instruction_cache_field_q <= sync_instruction_cache_field;
      end
    end
  end

  // ready flag, visible as an output; it rises on the same edge
  // that takes the snapshot, so the first request it admits
  // already reads the captured straps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else if (ce) begin
      ready_q <= (cfg_state_d == st_ready);
    end
  end

  // --------------------------------------------------------------
  // cache description fields
  // --------------------------------------------------------------
  // one encoder per cache; only the instruction side drives bit 11
  // size code 3 is not a real size and reads as the smallest cache
  assign data_cache_field.size_sel = data_cache_field_q;
  assign instruction_cache_field.size_sel = instruction_cache_field_q;

  cache_field_encoder #(
    .IS_INSTR(1'b0)
  ) u_data_enc (
    .port(data_cache_field)
  );

  cache_field_encoder #(
    .IS_INSTR(1'b1)
  ) u_instr_enc (
    .port(instruction_cache_field)
  );

  // --------------------------------------------------------------
  // register images
  // --------------------------------------------------------------
  // cache geometry: class code, split flag, both cache fields
  always_comb begin
    cache_geometry = '0;
    cache_geometry[cpu_id_pkg::CG_CLASS_LSB +: 4] = cpu_id_pkg::CG_CLASS;
    cache_geometry[cpu_id_pkg::CG_SEP_BIT] = cpu_id_pkg::CG_SEPARATE;
    cache_geometry[cpu_id_pkg::CG_DATA_LSB +: cpu_id_pkg::CF_W] =
      data_cache_field.field;
    cache_geometry[cpu_id_pkg::CG_INSTR_LSB +: cpu_id_pkg::CF_W] =
      instruction_cache_field.field;
  end

  // translation buffer: lockable counts and the unified flag
  always_comb begin
    translation_buffer_geometry = '0;
    translation_buffer_geometry[cpu_id_pkg::TB_ILOCK_LSB +: 8] = cpu_id_pkg::TB_ILOCK;
    translation_buffer_geometry[cpu_id_pkg::TB_DLOCK_LSB +: 8] = cpu_id_pkg::TB_DLOCK;
    translation_buffer_geometry[cpu_id_pkg::TB_SPLIT_BIT] = cpu_id_pkg::TB_UNIFIED;
  end

  // a slot strap beyond the configured cpu count would alias a
  // neighbour; clamp it so numbering stays within 0..NUM_CPUS-1
  always_comb begin
    if (slot_q > MAX_SLOT) begin
      slot_clamped = MAX_SLOT;
    end else begin
      slot_clamped = slot_q;
    end
  end

  // processor number: cluster above, cpu slot below; bits 7..2
  // and everything above the cluster stay zero
  always_comb begin
    processor_number = '0;
    processor_number[cpu_id_pkg::PN_CLUSTER_LSB +: 4] = cluster_q;
    processor_number[cpu_id_pkg::PN_CPU_LSB +: 2] = slot_clamped;
  end

  // fixed feature words
  assign execution_state_features = cpu_id_pkg::EXEC_FEAT_VAL;
  assign programmer_model_features = cpu_id_pkg::PROG_FEAT_VAL;

  // --------------------------------------------------------------
  // selector decode
  // --------------------------------------------------------------
  // the main identification word is not held here, so c0,c0,0
  // and every other selector fall out as a miss; the c0,c1 row is
  // decoded in full, so each second opcode there counts as a hit
  always_comb begin
    sel_hit = 1'b0;
    sel_val = cpu_id_pkg::ZERO_WORD;
    if (xfer_crn != cpu_id_pkg::CRN_ID || xfer_op1 != cpu_id_pkg::OP1_ID) begin
      sel_hit = 1'b0;
    end else if (xfer_crm == cpu_id_pkg::CRM_GEOM) begin
      if (xfer_op2 == cpu_id_pkg::OP2_CACHE) begin
        sel_hit = 1'b1;
        sel_val = cache_geometry;
      end else if (xfer_op2 == cpu_id_pkg::OP2_TLB) begin
        sel_hit = 1'b1;
        sel_val = translation_buffer_geometry;
      end else if (xfer_op2 == cpu_id_pkg::OP2_PROCNUM) begin
        sel_hit = 1'b1;
        sel_val = processor_number;
      end
    end else if (xfer_crm == cpu_id_pkg::CRM_FEAT) begin
      sel_hit = 1'b1;
      if (xfer_op2 == cpu_id_pkg::OP2_EXEC_FEAT) begin
        sel_val = execution_state_features;
      end else if (xfer_op2 == cpu_id_pkg::OP2_PROG_FEAT) begin
        sel_val = programmer_model_features;
      end else if (xfer_op2 == cpu_id_pkg::OP2_DEBUG_FEAT) begin
        sel_val = DEBUG_FEATURES;
      end else if (xfer_op2 == cpu_id_pkg::OP2_FEAT_RSVD) begin
        sel_val = cpu_id_pkg::ZERO_WORD;
      end else if (xfer_op2 == cpu_id_pkg::OP2_MM0) begin
        sel_val = MM_FEATURES0;
      end else if (xfer_op2 == cpu_id_pkg::OP2_MM1) begin
        sel_val = MM_FEATURES1;
      end else if (xfer_op2 == cpu_id_pkg::OP2_MM2) begin
        sel_val = MM_FEATURES2;
      end else begin
        sel_val = MM_FEATURES3;
      end
    end
  end

  // --------------------------------------------------------------
  // transfer acceptance
  // --------------------------------------------------------------
  // a hit is refused when the core is unprivileged or writing;
  // the bank has no writable bit, so a refusal changes nothing.
  // a miss wins over a refusal: a selector owned elsewhere must
  // reach its owner even from an unprivileged core
  assign take = ready_q && xfer_valid;
  assign refuse = !xfer_priv || xfer_write;

  // --------------------------------------------------------------
  // answer strobes
  // --------------------------------------------------------------
  // exactly one strobe per taken transfer, one cycle after it;
  // with ce low a strobe simply stands until the clock runs again,
  // so the consumer must qualify it with ce as well
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
      undef_q <= 1'b0;
      miss_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= take && sel_hit && !refuse;
      undef_q <= take && sel_hit && refuse;
      miss_q <= take && !sel_hit;
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  // data only moves on a successful read and holds otherwise,
  // so a refused access leaves the visible word untouched; the
  // hold costs a 32-bit enable but spares the core a stale-zero read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= cpu_id_pkg::ZERO_WORD;
    end else if (ce) begin
      if (take && sel_hit && !refuse) begin
        rd_data_q <= sel_val;
      end
    end
  end

endmodule

// *** hdl/cpu_id_pkg.sv ***
package cpu_id_pkg;

  // ----------------------------------------------------------------
  // transfer selectors
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam logic [3:0] CRN_ID = 4'h0;
  localparam logic [3:0] CRM_GEOM = 4'h0;
  localparam logic [3:0] CRM_FEAT = 4'h1;
  localparam logic [2:0] OP1_ID = 3'h0;
  localparam logic [2:0] OP2_CACHE = 3'h1;
  localparam logic [2:0] OP2_TLB = 3'h3;
  localparam logic [2:0] OP2_PROCNUM = 3'h5;
  localparam logic [2:0] OP2_EXEC_FEAT = 3'h0;
  localparam logic [2:0] OP2_PROG_FEAT = 3'h1;
  localparam logic [2:0] OP2_DEBUG_FEAT = 3'h2;
  localparam logic [2:0] OP2_FEAT_RSVD = 3'h3;
  localparam logic [2:0] OP2_MM0 = 3'h4;
  localparam logic [2:0] OP2_MM1 = 3'h5;
  localparam logic [2:0] OP2_MM2 = 3'h6;
  localparam logic [2:0] OP2_MM3 = 3'h7;

  // ----------------------------------------------------------------
  // cache geometry layout
  // ----------------------------------------------------------------
  localparam int CG_CLASS_LSB = 25;
  localparam int CG_SEP_BIT = 24;
  localparam int CG_DATA_LSB = 12;
  localparam int CG_INSTR_LSB = 0;
  localparam logic [3:0] CG_CLASS = 4'he;
  localparam logic CG_SEPARATE = 1'b1;
  localparam int CF_W = 12;
  localparam int CF_BIG_BIT = 11;
  localparam int CF_SIZE_LSB = 6;
  localparam int CF_ASSOC_LSB = 3;
  localparam int CF_LINE_LSB = 0;
  localparam logic [2:0] CF_SIZE_16K = 3'h5;
  localparam logic [2:0] CF_SIZE_32K = 3'h6;
  localparam logic [2:0] CF_SIZE_64K = 3'h7;
  localparam logic [2:0] CF_ASSOC_4WAY = 3'h2;
  localparam logic [1:0] CF_LINE_8WORD = 2'h2;
  localparam logic [1:0] CSEL_16K = 2'h0;
  localparam logic [1:0] CSEL_32K = 2'h1;
  localparam logic [1:0] CSEL_64K = 2'h2;

  // ----------------------------------------------------------------
  // translation buffer, processor number, features
  // ----------------------------------------------------------------
  localparam int TB_ILOCK_LSB = 16;
  localparam int TB_DLOCK_LSB = 8;
  localparam int TB_SPLIT_BIT = 0;
  localparam logic [7:0] TB_ILOCK = 8'h00;
  localparam logic [7:0] TB_DLOCK = 8'h08;
  localparam logic TB_UNIFIED = 1'b0;
  localparam int PN_CLUSTER_LSB = 8;
  localparam int PN_CPU_LSB = 0;
  localparam logic [31:0] EXEC_FEAT_VAL = 32'h0000_0111;
  localparam logic [31:0] PROG_FEAT_VAL = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // configuration capture timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

endpackage

// *** hdl/cache_field_if.sv ***
`timescale 1ns/1ns
// size selection in, 12-bit cache description out
interface cache_field_if;
  logic [1:0] size_sel;
  logic [11:0] field;
  modport enc (input size_sel, output field);
  modport user (output size_sel, input field);
endinterface

// *** hdl/cache_field_encoder.sv ***
`timescale 1ns/1ns
module cache_field_encoder #(
  parameter bit IS_INSTR = 1'b0
) (
  cache_field_if.enc port
);

  logic [2:0] size_code;

  // --------------------------------------------------------------
  // size coding
  // --------------------------------------------------------------
  // unused selection code 3 falls back to the smallest cache
  always_comb begin
    if (port.size_sel == cpu_id_pkg::CSEL_32K) begin
      size_code = cpu_id_pkg::CF_SIZE_32K;
    end else if (port.size_sel == cpu_id_pkg::CSEL_64K) begin
      size_code = cpu_id_pkg::CF_SIZE_64K;
    end else begin
      size_code = cpu_id_pkg::CF_SIZE_16K;
    end
  end

  // --------------------------------------------------------------
  // field assembly
  // --------------------------------------------------------------
  // every bit not set here reads zero
  always_comb begin
    port.field = '0;
    port.field[cpu_id_pkg::CF_SIZE_LSB +: 3] = size_code;
    port.field[cpu_id_pkg::CF_ASSOC_LSB +: 3] = cpu_id_pkg::CF_ASSOC_4WAY;
    port.field[cpu_id_pkg::CF_LINE_LSB +: 2] = cpu_id_pkg::CF_LINE_8WORD;
    if (IS_INSTR) begin
      port.field[cpu_id_pkg::CF_BIG_BIT] = (size_code != cpu_id_pkg::CF_SIZE_16K);
    end
  end

endmodule

// *** bench/cpu_identification_regs_assertions.sv ***
`timescale 1ns/1ns
module cpu_identification_regs_checker #(
  parameter int unsigned NUM_CPUS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic xfer_priv,
  input wire logic [2:0] xfer_op1,
  input wire logic [3:0] xfer_crn,
  input wire logic [3:0] xfer_crm,
  input wire logic [2:0] xfer_op2,
  input wire logic [3:0] cluster_number_pins,
  input wire logic [31:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic undef_q,
  input wire logic miss_q,
  input wire logic ready_q
);
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic take;
  logic hit;
  logic rd_ok;
  logic sel00;

  // decoded from the selectors only, so a wrong decode in the design shows
  assign take = ce && ready_q && xfer_valid;
  assign sel00 = xfer_crn == 4'h0 && xfer_op1 == 3'h0 && xfer_crm == 4'h0;
  assign hit = xfer_crn == 4'h0 && xfer_op1 == 3'h0 &&
    (xfer_crm == 4'h1 || (xfer_crm == 4'h0 && xfer_op2 inside {3'h1, 3'h3, 3'h5}));
  assign rd_ok = take && hit && xfer_priv && !xfer_write;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  one_answer_a: assert property (take |=> $onehot({rd_valid_q, undef_q, miss_q}))
    else $error("taken request without exactly one answer");
  idle_quiet_a: assert property (ce && !take |=> !(rd_valid_q || undef_q || miss_q))
    else $error("answer without a taken request");
  refused_access_a: assert property (take && hit && (!xfer_priv || xfer_write) |=> undef_q)
    else $error("unprivileged or write access not refused");
  foreign_select_a: assert property (take && !hit |=> miss_q)
    else $error("foreign selector not answered as miss");
  refuse_keeps_a: assert property (undef_q || miss_q |-> $stable(rd_data_q))
    else $error("read data changed on refused access");

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  geom_class_a: assert property (rd_ok && sel00 && xfer_op2 == 3'h1 |=>
    rd_valid_q && rd_data_q[31:24] == 8'h1d)
    else $error("cache geometry class bits wrong");
  geom_fields_a: assert property (rd_ok && sel00 && xfer_op2 == 3'h1 |=>
    rd_data_q[23:21] == 3'h0 && rd_data_q[20:18] >= 3'h5 && rd_data_q[17:12] == 6'h12 &&
    rd_data_q[10:9] == 2'h0 && rd_data_q[8:6] >= 3'h5 && rd_data_q[5:0] == 6'h12 &&
    rd_data_q[11] == (rd_data_q[8:6] != 3'h5))
    else $error("cache field layout wrong");
  tlb_word_a: assert property (rd_ok && sel00 && xfer_op2 == 3'h3 |=>
    rd_valid_q && rd_data_q == 32'h0000_0800)
    else $error("translation buffer word wrong");
  proc_number_a: assert property (rd_ok && sel00 && xfer_op2 == 3'h5 |=>
    rd_data_q[31:12] == 20'h0_0000 && rd_data_q[7:2] == 6'h00 &&
    rd_data_q[11:8] == cluster_number_pins && rd_data_q[1:0] <= NUM_CPUS - 1)
    else $error("processor number word wrong");
  feature_word_a: assert property (rd_ok && xfer_crm == 4'h1 && xfer_op2 inside {3'h0, 3'h1, 3'h3}
    |=> rd_data_q == (($past(xfer_op2) == 3'h0) ? 32'h0000_0111 :
    ($past(xfer_op2) == 3'h1) ? 32'h0000_0001 : 32'h0000_0000))
    else $error("feature word wrong");
endmodule

bind cpu_identification_regs cpu_identification_regs_checker #(.NUM_CPUS(NUM_CPUS)) i_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .xfer_valid(xfer_valid), .xfer_write(xfer_write),
  .xfer_priv(xfer_priv), .xfer_op1(xfer_op1), .xfer_crn(xfer_crn), .xfer_crm(xfer_crm),
  .xfer_op2(xfer_op2), .cluster_number_pins(cluster_number_pins), .rd_data_q(rd_data_q),
  .rd_valid_q(rd_valid_q), .undef_q(undef_q), .miss_q(miss_q), .ready_q(ready_q));

// *** bench/tb_cpu_identification_regs.sv ***
`timescale 1ns/1ns
module tb_cpu_identification_regs;
  // ----------------------------------------------------------------
  // set-up: three cpus so that slot code 3 must be clamped
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CPUS = 3;
  localparam logic [31:0] DBG_W = 32'h0000_0002;
  localparam logic [31:0] MM_W [4] = '{32'h0110_1103, 32'h1002_0302, 32'h0122_2000,
    32'h0000_0f0f};
  localparam logic [9:0] CFGS [4] = '{{4'h5, 2'h0, 2'h0, 2'h0}, {4'ha, 2'h1, 2'h1, 2'h2},
    {4'h3, 2'h3, 2'h2, 2'h1}, {4'hc, 2'h2, 2'h3, 2'h3}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic xfer_valid = 1'b0;
  logic xfer_write = 1'b0;
  logic xfer_priv = 1'b1;
  logic [2:0] xfer_op1 = 3'h0;
  logic [2:0] xfer_op2 = 3'h0;
  logic [3:0] xfer_crn = 4'h0;
  logic [3:0] xfer_crm = 4'h0;
  logic [3:0] cluster_number_pins = 4'h0;
  logic [1:0] cpu_slot_pins = 2'h0;
  logic [1:0] dcache_size_pins = 2'h0;
  logic [1:0] icache_size_pins = 2'h0;
  logic [31:0] rd_data_q;
  logic rd_valid_q;
  logic undef_q;
  logic miss_q;
  logic ready_q;
  logic [31:0] last_q;
  logic [31:0] feat [8];
  int err_count = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  cpu_identification_regs #(.NUM_CPUS(NUM_CPUS), .DEBUG_FEATURES(DBG_W),
    .MM_FEATURES0(MM_W[0]), .MM_FEATURES1(MM_W[1]), .MM_FEATURES2(MM_W[2]),
    .MM_FEATURES3(MM_W[3])) i_cpu_identification_regs (
    .clk(clk), .nrst(nrst), .ce(ce), .xfer_valid(xfer_valid), .xfer_write(xfer_write),
    .xfer_priv(xfer_priv), .xfer_op1(xfer_op1), .xfer_crn(xfer_crn), .xfer_crm(xfer_crm),
    .xfer_op2(xfer_op2), .cluster_number_pins(cluster_number_pins),
    .cpu_slot_pins(cpu_slot_pins), .dcache_size_pins(dcache_size_pins),
    .icache_size_pins(icache_size_pins), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .undef_q(undef_q), .miss_q(miss_q), .ready_q(ready_q));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected 12-bit cache description; select code 3 falls back to 16KB
  function automatic logic [11:0] cfield(input logic [1:0] sel, input bit instr);
    logic [2:0] sz;
    sz = (sel == 2'h1) ? 3'b110 : (sel == 2'h2) ? 3'b111 : 3'b101;
    return {instr && (sz != 3'b101), 2'b00, sz, 3'b010, 1'b0, 2'b10};
  endfunction

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // valid stays high so back-to-back calls give one request per edge
  task automatic xfer(input logic wr, input logic pv, input logic [2:0] op1,
                      input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2);
    xfer_valid = 1'b1;
    xfer_write = wr;
    xfer_priv = pv;
    xfer_op1 = op1;
    xfer_crn = crn;
    xfer_crm = crm;
    xfer_op2 = op2;
    @(posedge clk);
    #1;
  endtask

  task automatic idle();
    xfer_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic read_chk(input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] exp);
    xfer(1'b0, 1'b1, 3'h0, 4'h0, crm, op2);
    chk3({rd_valid_q, undef_q, miss_q}, 3'b100);
    chk32(rd_data_q, exp);
    last_q = exp;
  endtask

  task automatic refuse(input logic wr, input logic pv, input logic [2:0] op1,
                        input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
                        input logic [2:0] flags);
    xfer(wr, pv, op1, crn, crm, op2);
    chk3({rd_valid_q, undef_q, miss_q}, flags);
    chk32(rd_data_q, last_q);
  endtask

  // pins only change while reset holds, as the snapshot is taken once
  task automatic restart(input logic [9:0] c);
    int n;
    xfer_valid = 1'b0;
    nrst = 1'b0;
    {cluster_number_pins, cpu_slot_pins, dcache_size_pins, icache_size_pins} = c;
    repeat (16) @(posedge clk);
    #1;
    chk3({rd_valid_q, undef_q, miss_q}, 3'b000);
    chk32(rd_data_q, 32'h0000_0000);
    chk3({2'b00, ready_q}, 3'b000);
    nrst = 1'b1;
    // requests before the snapshot is ready must be ignored
    repeat (3) begin
      xfer(1'b0, 1'b1, 3'h0, 4'h0, 4'h0, 3'h1);
      chk3({rd_valid_q, undef_q, miss_q}, 3'b000);
    end
    idle();
    n = 0;
    while (ready_q !== 1'b1 && n < 20) begin
      idle();
      n++;
    end
    chk3({2'b00, ready_q}, 3'b001);
    last_q = 32'h0000_0000;
  endtask

  task automatic test_done();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: whole run is under two hundred cycles
  // ----------------------------------------------------------------
  initial begin
    #20000;
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence: one pass per pin configuration
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] geom;
    logic [1:0] slot;
    feat = '{32'h0000_0111, 32'h0000_0001, DBG_W, 32'h0000_0000, MM_W[0], MM_W[1], MM_W[2],
      MM_W[3]};
    for (int k = 0; k < 4; k++) begin
      restart(CFGS[k]);
      geom = {3'b000, 4'b1110, 1'b1, cfield(dcache_size_pins, 1'b0),
        cfield(icache_size_pins, 1'b1)};
      slot = (cpu_slot_pins > NUM_CPUS - 1) ? 2'(NUM_CPUS - 1) : cpu_slot_pins;
      read_chk(4'h0, 3'h1, geom);
      read_chk(4'h0, 3'h3, 32'h0000_0800);
      read_chk(4'h0, 3'h5, {20'h0_0000, cluster_number_pins, 6'h00, slot});
      for (int op = 0; op < 8; op++) begin
        read_chk(4'h1, 3'(op), feat[op]);
      end
      refuse(1'b0, 1'b0, 3'h0, 4'h0, 4'h0, 3'h1, 3'b010);
      refuse(1'b1, 1'b1, 3'h0, 4'h0, 4'h1, 3'h0, 3'b010);
      refuse(1'b0, 1'b0, 3'h0, 4'h0, 4'h1, 3'h3, 3'b010);
      refuse(1'b0, 1'b1, 3'h0, 4'h0, 4'h0, 3'h0, 3'b001);
      refuse(1'b0, 1'b0, 3'h1, 4'h0, 4'h0, 3'h1, 3'b001);
      refuse(1'b0, 1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 3'b001);
      read_chk(4'h0, 3'h1, geom);
      // a frozen clock enable must swallow the request without any answer
      idle();
      ce = 1'b0;
      refuse(1'b0, 1'b1, 3'h0, 4'h0, 4'h0, 3'h3, 3'b000);
      idle();
      ce = 1'b1;
      idle();
      chk3({rd_valid_q, undef_q, miss_q}, 3'b000);
      chk32(rd_data_q, geom);
    end
    test_done();
  end
endmodule
